// File: design/uart_irq_pkg.sv
// constants for the per-channel interrupt and queue setup block
// Behaviour
// - character timeout never reported in character mode
// - source code bits 7:6 read as ones in queue mode, zeros otherwise
// - disabled sources neither show in source code nor raise the interrupt
// - mask bit 0 enables data available and, in queue mode, timeout
// - mask bits 1,2,3 enable transmit empty, line status, modem status
// - mask bits 7:4 always read zero
// - eight-bit scratch register with no effect on anything
// - writes at source code address go to write-only queue setup
// - setup bit 0 enables both queues; mode switches never clear contents
// - other setup bits ignored unless the same write has bit 0 set
// - setup bit 1 pulses a receive queue counter reset, self-clearing
// - setup bit 2 pulses a transmit queue counter reset, self-clearing
// - setup bit 3 selects dma signalling mode 1 while queues enabled
// - setup bits 5:4 reserved, no effect
// - setup bits 7:6 pick trigger 1, 4, 8 or 14 bytes
// - source code bit 0 low while any enabled source pends; 0001 when none
// - source reported by a code read is latched at the address phase only; the live code keeps following the sources
// - source code bits 5:4 always read zero
package uart_irq_pkg;
   localparam logic [7:0] SRC_OFS = 8'h00;
   localparam logic [7:0] MASK_OFS = 8'h04;
   localparam logic [7:0] SCR_OFS = 8'h08;
   localparam logic [3:0] CODE_NONE = 4'h1;
   localparam logic [3:0] CODE_LINE = 4'h6;
   localparam logic [3:0] CODE_RXDATA = 4'h4;
   localparam logic [3:0] CODE_TMO = 4'hc;
   localparam logic [3:0] CODE_TXEMPTY = 4'h2;
   localparam logic [3:0] CODE_MODEM = 4'h0;
   localparam int EN_RX_BIT = 0;
   localparam int EN_TX_BIT = 1;
   localparam int EN_LINE_BIT = 2;
   localparam int EN_MODEM_BIT = 3;
   localparam int SET_EN_BIT = 0;
   localparam int SET_RXCLR_BIT = 1;
   localparam int SET_TXCLR_BIT = 2;
   localparam int SET_DMA_BIT = 3;
   localparam int SET_TRIG_LSB = 6;
   localparam logic [2:0] TMO_CHARS = 3'h4;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h1;

   function automatic logic [4:0] trig_bytes(input logic [1:0] sel);
      case (sel)
         2'h0: trig_bytes = 5'h01;
         2'h1: trig_bytes = 5'h04;
         2'h2: trig_bytes = 5'h08;
         default: trig_bytes = 5'h0e;
      endcase
   endfunction : trig_bytes
endpackage : uart_irq_pkg

// File: design/uart_irq_ctrl.sv
// interrupt priority, enable mask, scratch and queue setup registers on AHB-Lite
`timescale 1ns/10ps
module uart_irq_ctrl (
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic LINE_ERROR,
   input wire logic LINE_STATUS_READ,
   input wire logic [4:0] RX_LEVEL,
   input wire logic RX_PUSH,
   input wire logic RX_POP,
   input wire logic CHAR_TIME_TICK,
   input wire logic TX_EMPTY,
   input wire logic TX_WRITE,
   input wire logic MODEM_CHANGE,
   input wire logic MODEM_STATUS_READ,
   output logic IRQ_OUT,
   output logic QUEUE_ENABLE,
   output logic RX_QUEUE_CLEAR,
   output logic TX_QUEUE_CLEAR,
   output logic DMA_MODE_1
);

   logic acc;
   logic rd_src;
   logic wr_q;
   logic [7:0] wa_q;
   logic [7:0] mask_q;
   logic [7:0] scr_q;
   logic fifo_q;
   logic dma_q;
   logic [1:0] trig_q;
   logic line_q;
   logic thre_q;
   logic tx_empty_q;
   logic modem_q;
   logic [2:0] tmo_cnt_q;
   logic rx_avail;
   logic tmo_pend;
   logic [3:0] code;
   logic any_pend;

   ////////////////////////////////////////////////////////////////////////////
   // bus decode

   assign acc = HSEL && HTRANS[1] && HREADY;
   assign rd_src = acc && !HWRITE && (HADDR[7:0] == uart_irq_pkg::SRC_OFS);

   // zero-wait slave: address latched, write applied in data phase
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         wr_q <= 1'b0;
         wa_q <= uart_irq_pkg::RESET_BYTE;
      end else begin
         wr_q <= acc && HWRITE;
         wa_q <= HADDR[7:0];
      end
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         HREADYOUT <= 1'b0;
         HRESP <= 1'b0;
      end else begin
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end
   end

   // read data is formed at the address phase so the snapshot is frozen
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         HRDATA <= 32'h0;
      end else if (acc && !HWRITE) begin
         case (HADDR[7:0])
            uart_irq_pkg::SRC_OFS: HRDATA <= {24'h0, {2{fifo_q}}, 2'h0, code};
            uart_irq_pkg::MASK_OFS: HRDATA <= {28'h0, mask_q[3:0]};
            uart_irq_pkg::SCR_OFS: HRDATA <= {24'h0, scr_q};
            default: HRDATA <= 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // software registers

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         mask_q <= uart_irq_pkg::RESET_BYTE;
         scr_q <= uart_irq_pkg::RESET_BYTE;
      end else if (wr_q) begin
         if (wa_q == uart_irq_pkg::MASK_OFS) begin
            mask_q <= {4'h0, HWDATA[3:0]};
         end
         if (wa_q == uart_irq_pkg::SCR_OFS) begin
            scr_q <= HWDATA[7:0];
         end
      end
   end

   // setup is write-only; bits 5:4 are dropped on purpose
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         fifo_q <= 1'b0;
         dma_q <= 1'b0;
         trig_q <= 2'h0;
      end else if (wr_q && wa_q == uart_irq_pkg::SRC_OFS) begin
         fifo_q <= HWDATA[uart_irq_pkg::SET_EN_BIT];
         if (HWDATA[uart_irq_pkg::SET_EN_BIT]) begin
            dma_q <= HWDATA[uart_irq_pkg::SET_DMA_BIT];
            trig_q <= HWDATA[uart_irq_pkg::SET_TRIG_LSB +: 2];
         end
      end
   end

   // clear pulses last one cycle; the bits never read back so they self-clear
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         RX_QUEUE_CLEAR <= 1'b0;
         TX_QUEUE_CLEAR <= 1'b0;
      end else begin
         RX_QUEUE_CLEAR <= wr_q && wa_q == uart_irq_pkg::SRC_OFS
            && HWDATA[uart_irq_pkg::SET_EN_BIT] && HWDATA[uart_irq_pkg::SET_RXCLR_BIT];
         TX_QUEUE_CLEAR <= wr_q && wa_q == uart_irq_pkg::SRC_OFS
            && HWDATA[uart_irq_pkg::SET_EN_BIT] && HWDATA[uart_irq_pkg::SET_TXCLR_BIT];
      end
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         QUEUE_ENABLE <= 1'b0;
         DMA_MODE_1 <= 1'b0;
      end else begin
         QUEUE_ENABLE <= fifo_q;
         DMA_MODE_1 <= fifo_q && dma_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt sources; set wins over a same-cycle clear, except the timeout count, where a restart wins

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         line_q <= 1'b0;
      end else if (LINE_ERROR) begin
         line_q <= 1'b1;
      end else if (LINE_STATUS_READ) begin
         line_q <= 1'b0;
      end
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         modem_q <= 1'b0;
      end else if (MODEM_CHANGE) begin
         modem_q <= 1'b1;
      end else if (MODEM_STATUS_READ) begin
         modem_q <= 1'b0;
      end
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         tx_empty_q <= 1'b0;
         thre_q <= 1'b0;
      end else begin
         tx_empty_q <= TX_EMPTY;
         if (TX_EMPTY && !tx_empty_q) begin
            thre_q <= 1'b1;
         end else if (TX_WRITE || (rd_src && code == uart_irq_pkg::CODE_TXEMPTY)) begin
            thre_q <= 1'b0;
         end
      end
   end

   // a level in queue mode: follows the count against the trigger
   assign rx_avail = fifo_q ? (RX_LEVEL >= uart_irq_pkg::trig_bytes(trig_q))
                            : (RX_LEVEL != 5'h0);

   // counts idle character times; any push, pop or empty queue restarts it
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         tmo_cnt_q <= 3'h0;
      end else if (RX_PUSH || RX_POP || RX_LEVEL == 5'h0 || !fifo_q) begin
         tmo_cnt_q <= 3'h0;
      end else if (CHAR_TIME_TICK && tmo_cnt_q != uart_irq_pkg::TMO_CHARS) begin
         tmo_cnt_q <= tmo_cnt_q + 3'h1;
      end
   end

   assign tmo_pend = fifo_q && tmo_cnt_q == uart_irq_pkg::TMO_CHARS;

   ////////////////////////////////////////////////////////////////////////////
   // priority encoder and interrupt output

   always_comb begin
      if (line_q && mask_q[uart_irq_pkg::EN_LINE_BIT]) begin
         code = uart_irq_pkg::CODE_LINE;
      end else if (rx_avail && mask_q[uart_irq_pkg::EN_RX_BIT]) begin
         code = uart_irq_pkg::CODE_RXDATA;
      end else if (tmo_pend && mask_q[uart_irq_pkg::EN_RX_BIT]) begin
         code = uart_irq_pkg::CODE_TMO;
      end else if (thre_q && mask_q[uart_irq_pkg::EN_TX_BIT]) begin
         code = uart_irq_pkg::CODE_TXEMPTY;
      end else if (modem_q && mask_q[uart_irq_pkg::EN_MODEM_BIT]) begin
         code = uart_irq_pkg::CODE_MODEM;
      end else begin
         code = uart_irq_pkg::CODE_NONE;
      end
   end

   assign any_pend = !code[0];

   // one cycle behind the sources so the pin never glitches
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         IRQ_OUT <= 1'b0;
      end else begin
         IRQ_OUT <= any_pend;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RST_B);

   sequence setup_write_s(bit b);
      wr_q && wa_q == uart_irq_pkg::SRC_OFS && HWDATA[0] == b;
   endsequence

   line_set_a: assert property (LINE_ERROR |=> line_q)
      else $error("line status source not set");
   line_top_a: assert property (line_q && mask_q[2] |-> code == 4'h6)
      else $error("line status not reported first");
   tmo_char_a: assert property (!fifo_q |-> code != 4'hc)
      else $error("timeout reported in character mode");
   thre_clear_a: assert property (TX_WRITE && !(TX_EMPTY && !tx_empty_q) |=> !thre_q)
      else $error("transmit empty not cleared by write");
   modem_set_a: assert property (MODEM_CHANGE |=> modem_q ##0 code[0] == 1'b0 || !mask_q[3])
      else $error("modem change lost");
   src_top_a: assert property (rd_src |=> HRDATA[7:4] == {{2{$past(fifo_q)}}, 2'h0})
      else $error("source code upper bits wrong");
   mask_zero_a: assert property (acc && !HWRITE && HADDR[7:0] == 8'h04 |=> HRDATA[7:4] == 4'h0)
      else $error("mask upper bits not zero");
   setup_gate_a: assert property (setup_write_s(1'b0) |=> !fifo_q && $stable(trig_q) && $stable(dma_q))
      else $error("setup write without enable took effect");
   // a second clearing write right behind the first may hold the pulse one more cycle
   rx_clear_a: assert property (setup_write_s(1'b1) ##0 HWDATA[1] |=> RX_QUEUE_CLEAR ##1 (!RX_QUEUE_CLEAR || $past(wr_q)))
      else $error("receive clear pulse wrong");
   irq_pin_a: assert property (any_pend |=> IRQ_OUT)
      else $error("interrupt output not raised");
   // judged from the masked sources, not from the encoder, so a bad encoder shows up here
   irq_quiet_a: assert property (!(line_q && mask_q[2]) && !(rx_avail && mask_q[0])
      && !(tmo_pend && mask_q[0]) && !(thre_q && mask_q[1]) && !(modem_q && mask_q[3])
      |=> !IRQ_OUT)
      else $error("interrupt output without enabled source");

endmodule : uart_irq_ctrl

// File: test/uart_host_model.sv
// host side bus master model issuing single-word AHB-Lite transfers
`timescale 1ns/10ps
module uart_host_model (
   input wire logic MCLK,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   output logic HSEL,
   output logic [31:0] HADDR,
   output logic [1:0] HTRANS,
   output logic HWRITE,
   output logic [2:0] HSIZE,
   output logic [31:0] HWDATA
);
   initial begin
      HSEL = 1'b0;
      HADDR = 32'h0;
      HTRANS = 2'h0;
      HWRITE = 1'b0;
      HSIZE = 3'h2;
      HWDATA = 32'h0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // each phase held until hready is seen high, so a slow slave is served as well
   task xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
      output logic [31:0] rd);
      @(posedge MCLK);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HADDR <= {24'h0, addr};
      HWRITE <= wr;
      do @(posedge MCLK); while (HREADY !== 1'b1);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      do @(posedge MCLK); while (HREADY !== 1'b1);
      rd = HRDATA;
   endtask : xfer
endmodule : uart_host_model

// File: test/uart_irq_ctrl_test.sv
// self-checking bench for the interrupt priority and queue setup block
`timescale 1ns/10ps
module uart_irq_ctrl_test;
   localparam logic [7:0] SRC = uart_irq_pkg::SRC_OFS;
   localparam logic [7:0] MASK = uart_irq_pkg::MASK_OFS;
   logic MCLK = 1'b0;
   logic RST_B = 1'b0;
   logic TX_EMPTY = 1'b0;
   logic [4:0] RX_LEVEL = 5'h00;
   logic [7:0] sp = 8'h00;
   logic HSEL, HWRITE, HREADYOUT, HRESP, IRQ_OUT;
   logic QUEUE_ENABLE, RX_QUEUE_CLEAR, TX_QUEUE_CLEAR, DMA_MODE_1;
   logic [1:0] HTRANS;
   logic [2:0] HSIZE;
   logic [31:0] HADDR, HWDATA, HRDATA;
   int mismatches = 0;
   int compares = 0;
   int cycles = 0;
   always #4 MCLK = ~MCLK;
   uart_host_model uart_host_model_inst (.MCLK(MCLK), .HREADY(HREADYOUT), .HRDATA(HRDATA),
      .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
      .HWDATA(HWDATA));
   // sp bits: line error, line read, push, pop, tick, tx write, modem change, modem read
   uart_irq_ctrl uart_irq_ctrl_inst (.MCLK(MCLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .LINE_ERROR(sp[0]),
      .LINE_STATUS_READ(sp[1]), .RX_LEVEL(RX_LEVEL), .RX_PUSH(sp[2]), .RX_POP(sp[3]),
      .CHAR_TIME_TICK(sp[4]), .TX_EMPTY(TX_EMPTY), .TX_WRITE(sp[5]), .MODEM_CHANGE(sp[6]),
      .MODEM_STATUS_READ(sp[7]), .IRQ_OUT(IRQ_OUT), .QUEUE_ENABLE(QUEUE_ENABLE),
      .RX_QUEUE_CLEAR(RX_QUEUE_CLEAR), .TX_QUEUE_CLEAR(TX_QUEUE_CLEAR), .DMA_MODE_1(DMA_MODE_1));
   ////////////////////////////////////////////////////////////////////////////////
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      uart_host_model_inst.xfer(1'b1, a, {24'h0, d}, r);
   endtask : wr
   task rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [31:0] r;
      uart_host_model_inst.xfer(1'b0, a, 32'h0, r);
      check($sformatf("register %h", a), r, {24'h0, exp});
   endtask : rchk
   task pulse(input int i);
      @(posedge MCLK) sp[i] <= 1'b1;
      @(posedge MCLK) sp <= 8'h00;
   endtask : pulse
   task lvl(input logic [4:0] v);
      @(posedge MCLK) RX_LEVEL <= v;
      @(posedge MCLK);
   endtask : lvl
   ////////////////////////////////////////////////////////////////////////////////
   task t_regs();
      rchk(SRC, 8'h01);
      rchk(MASK, 8'h00);
      wr(MASK, 8'hff);
      rchk(MASK, 8'h0f);
      wr(8'h08, 8'ha5);
      rchk(8'h08, 8'ha5);
      rchk(8'h0c, 8'h00);
      rchk(SRC, 8'h01);
      $display("test regs done");
   endtask : t_regs
   task t_prio();
      pulse(6);
      rchk(SRC, 8'h00);
      check("irq", IRQ_OUT, 32'h1);
      @(posedge MCLK) TX_EMPTY <= 1'b1;
      rchk(SRC, 8'h02);
      rchk(SRC, 8'h00);
      lvl(5'h01);
      rchk(SRC, 8'h04);
      pulse(0);
      rchk(SRC, 8'h06);
      pulse(1);
      rchk(SRC, 8'h04);
      lvl(5'h00);
      rchk(SRC, 8'h00);
      pulse(7);
      rchk(SRC, 8'h01);
      check("irq", IRQ_OUT, 32'h0);
      @(posedge MCLK) TX_EMPTY <= 1'b0;
      @(posedge MCLK) TX_EMPTY <= 1'b1;
      repeat (3) @(posedge MCLK);
      check("irq", IRQ_OUT, 32'h1);
      pulse(5);
      rchk(SRC, 8'h01);
      $display("test priority done");
   endtask : t_prio
   task t_mask();
      wr(MASK, 8'h00);
      pulse(6);
      rchk(SRC, 8'h01);
      check("irq", IRQ_OUT, 32'h0);
      wr(MASK, 8'h08);
      rchk(SRC, 8'h00);
      pulse(7);
      wr(MASK, 8'h01);
      $display("test mask done");
   endtask : t_mask
   task t_queue();
      static logic [4:0] trig [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
      for (int i = 0; i < 4; i++) begin
         wr(SRC, {i[1:0], 6'h01});
         lvl(trig[i] - 5'h01);
         rchk(SRC, 8'hc1);
         lvl(trig[i]);
         rchk(SRC, 8'hc4);
      end
      check("queue", QUEUE_ENABLE, 32'h1);
      $display("test queue done");
   endtask : t_queue
   task t_setup();
      wr(SRC, 8'h03);
      #1 check("rx clear", RX_QUEUE_CLEAR, 32'h1);
      @(posedge MCLK) #1 check("rx clear", RX_QUEUE_CLEAR, 32'h0);
      wr(SRC, 8'h05);
      #1 check("tx clear", TX_QUEUE_CLEAR, 32'h1);
      @(posedge MCLK) #1 check("tx clear", TX_QUEUE_CLEAR, 32'h0);
      // the dma mode output follows the stored setup one edge after the write lands
      wr(SRC, 8'h09);
      @(posedge MCLK) #1 check("dma", DMA_MODE_1, 32'h1);
      wr(SRC, 8'h01);
      @(posedge MCLK) #1 check("dma", DMA_MODE_1, 32'h0);
      wr(SRC, 8'h0a);
      #1 check("rx clear", RX_QUEUE_CLEAR, 32'h0);
      @(posedge MCLK) #1 check("dma", DMA_MODE_1, 32'h0);
      check("queue", QUEUE_ENABLE, 32'h0);
      rchk(SRC, 8'h04);
      wr(SRC, 8'h31);
      rchk(SRC, 8'hc4);
      $display("test setup done");
   endtask : t_setup
   task t_timeout();
      wr(SRC, 8'h41);
      lvl(5'h01);
      pulse(2);
      repeat (3) pulse(4);
      rchk(SRC, 8'hc1);
      pulse(4);
      rchk(SRC, 8'hcc);
      pulse(3);
      rchk(SRC, 8'hc1);
      lvl(5'h05);
      repeat (4) pulse(4);
      rchk(SRC, 8'hc4);
      wr(SRC, 8'h00);
      lvl(5'h01);
      repeat (4) pulse(4);
      rchk(SRC, 8'h04);
      $display("test timeout done");
   endtask : t_timeout
   ////////////////////////////////////////////////////////////////////////////////
   task conclude();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : conclude
   initial begin
      repeat (20) @(posedge MCLK);
      RST_B <= 1'b1;
      repeat (2) @(posedge MCLK);
      t_regs();
      t_prio();
      t_mask();
      t_queue();
      t_setup();
      t_timeout();
      conclude();
   end
   // the whole run needs well under a thousand cycles
   always @(posedge MCLK) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         conclude();
      end
   end
endmodule : uart_irq_ctrl_test
